// ---- src/pulse_gen_defs.vh ----
// Register map, field layout, reset values and codes of the triggered pulse generator
// ==========================================================================
// Contract
// [R1] With a driver attached, start in voltage operation with full supervision.
// [R2] Current operation may be selected only after a successful calibration.
// [R3] In current operation each current set point change recomputes the precharge voltage.
// [R4] Current operation: voltage at least minimum calibration voltage, current at most maximum.
// [R5] Operator reruns calibration after changing minimum voltage or maximum current.
// [R6] Operator recalibrates after swapping diode or driver; device cannot detect it.
// [R7] No driver: standalone generator, only width, rate, trigger and enable matter.
// [R8] Calibration never drives current above 99 percent of maximum diode current; the code applies the first voltage step unchecked.
// [R9] Minimum load current not reached at calibration start aborts with an error.
// [R10] Calibration steps linear voltage points, measures current, stores points on success.
// [R11] Pulses only while trigger condition holds and output is enabled.
// [R12] Edge trigger code 1 is rising edge, code 0 falling edge.
// [R13] Each qualifying edge launches a burst of the configured pulse count.
// [R14] Level trigger: code 5 pulses while input high, code 4 while low.
// [R15] Codes 2 and 3 select internal free-running pulse train.
// [R16] Only one external trigger input may be driven at a time.
// [R17] A started burst always completes despite further edges.
// [R18] Settings giving current above maximum disable the output automatically.
// [R19] Trigger codes above five are rejected, keeping the previous mode.
// [R20] Failed calibration keeps the old table and current mode availability.
`ifndef PULSE_GEN_DEFS_VH
`define PULSE_GEN_DEFS_VH

// Word offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_WIDTH 8'h04
`define REG_PERIOD 8'h08
`define REG_TRIG 8'h0C
`define REG_SHOTS 8'h10
`define REG_VSET 8'h14
`define REG_ISET 8'h18
`define REG_IMAX 8'h1C
`define REG_UMIN 8'h20
`define REG_STATUS 8'h24
`define REG_IMEAS 8'h28

// Control register fields
`define CTRL_ENABLE 0
`define CTRL_CURMODE 1
`define CTRL_CALSTART 2

// Status word fields
`define ST_CURMODE 0
`define ST_CALVALID 1
`define ST_CALBUSY 2
`define ST_CALERR 3
`define ST_OVERCUR 4
`define ST_DRIVER 5
`define ST_OUTEN 6
`define ST_MODEREJ 7

// Trigger codes
`define TRIG_FALL 3'h0
`define TRIG_RISE 3'h1
`define TRIG_INT_A 3'h2
`define TRIG_INT_B 3'h3
`define TRIG_LOW 3'h4
`define TRIG_HIGH 3'h5
`define TRIG_MAX 3'h5

// Reset values, in clock cycles and codes
`define WIDTH_RST 32'h00000004
`define PERIOD_RST 32'h00000028
`define SHOTS_RST 16'h0001
`define IMAX_RST 16'hFFFF
`define TRIG_RST 3'h2

// Calibration
`define CAL_POINTS 8
`define CAL_PCT_NUM 99
`define CAL_PCT_DEN 100
`define CAL_SETTLE 16'h0100
`define IMIN_LOAD 16'h0010

`endif

// ---- src/triggered_pulse_generator.v ----
// Triggered pulse generator with calibration and Avalon-MM register slave
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_gen_defs.vh"

module triggered_pulse_generator (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [1:0] response,
  // Driver presence and external trigger
  input wire driverPresent,
  input wire extTrigger,
  // Measured diode current from the driver ADC
  input wire [15:0] currentMeas,
  // Outputs to driver or coaxial stage
  output reg pulseOut,
  output reg [15:0] prechargeVolt,
  output reg calBusy
);

  // ==========================================================================
  // Registers
  reg enable_r;
  reg curMode_r;
  reg [31:0] width_r;
  reg [31:0] period_r;
  reg [2:0] trig_r;
  reg [15:0] shots_r;
  reg [15:0] vSet_r;
  reg [15:0] iSet_r;
  reg [15:0] iMax_r;
  reg [15:0] uMin_r;
  reg calValid_r;
  reg calErr_r;
  reg overCur_r;
  reg modeRej_r;
  reg ack_r;
  reg [15:0] calV [0:`CAL_POINTS-1];
  reg [15:0] calI [0:`CAL_POINTS-1];
  reg [15:0] tmpV [0:`CAL_POINTS-1];
  reg [15:0] tmpI [0:`CAL_POINTS-1];
  reg recompute_r;
  integer k;
  integer j;

  wire [31:0] wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
  // Writes land at the acknowledge edge; reads are fetched a cycle early so
  // the registered data stands while waitrequest is low
  wire wr = write & ack_r;
  wire rd = read & ~ack_r;

  // Merge write data into an old value under byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [31:0] m;
    begin
      merge = (old & ~m) | (d & m);
    end
  endfunction

  // Calibration current limit, 99 percent of the maximum
  wire [31:0] iLimProd = {16'h0000, iMax_r} * `CAL_PCT_NUM;
  wire [31:0] iLimQuot = iLimProd / `CAL_PCT_DEN;
  wire [15:0] iLim = iLimQuot[15:0];
  wire [31:0] shotsMerged = merge({16'h0000, shots_r}, writedata, wmask);

  // Standalone use ignores current operation entirely
  wire effCur = curMode_r & driverPresent & calValid_r; // [R7]
  wire calStartW = wr && address == `REG_CTRL && byteenable[0] &&
                   writedata[`CTRL_CALSTART] && driverPresent && !calBusy;

  // ==========================================================================
  // Bus answer: one wait cycle, then acknowledge
  assign waitrequest = (read | write) & ~ack_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (read | write) & ~ack_r;
    end
  end

  // ==========================================================================
  // Register writes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_r <= 1'b0;
      curMode_r <= 1'b0; // [R1]
      width_r <= `WIDTH_RST;
      period_r <= `PERIOD_RST;
      trig_r <= `TRIG_RST;
      shots_r <= `SHOTS_RST;
      iSet_r <= 16'h0000;
      iMax_r <= `IMAX_RST;
      uMin_r <= 16'h0000;
      modeRej_r <= 1'b0;
      recompute_r <= 1'b0;
    end else begin
      recompute_r <= 1'b0;
      if (overCur_r && driverPresent) begin
        enable_r <= 1'b0; // [R18]
      end
      if (wr) begin
        if (address == `REG_CTRL) begin
          if (byteenable[0]) begin
            enable_r <= writedata[`CTRL_ENABLE];
            // Current operation only with a valid table
            curMode_r <= writedata[`CTRL_CURMODE] & calValid_r; // [R2] [R20]
          end
        end else if (address == `REG_WIDTH) begin
          width_r <= merge(width_r, writedata, wmask);
        end else if (address == `REG_PERIOD) begin
          period_r <= merge(period_r, writedata, wmask);
        end else if (address == `REG_TRIG) begin
          if (byteenable[0]) begin
            if (writedata[31:0] <= {29'h0, `TRIG_MAX}) begin
              trig_r <= writedata[2:0];
              modeRej_r <= 1'b0;
            end else begin
              modeRej_r <= 1'b1; // [R19]
            end
          end
        end else if (address == `REG_SHOTS) begin
          shots_r <= shotsMerged[15:0];
        end else if (address == `REG_ISET) begin
          // Clamp to the maximum diode current
          iSet_r <= (writedata[15:0] > iMax_r) ? iMax_r : writedata[15:0]; // [R4]
          recompute_r <= 1'b1; // [R3]
        end else if (address == `REG_IMAX) begin
          iMax_r <= writedata[15:0];
        end else if (address == `REG_UMIN) begin
          uMin_r <= writedata[15:0];
        end
      end
    end
  end

  // ==========================================================================
  // Calibration sequencer
  localparam CAL_IDLE = 2'h0;
  localparam CAL_SETTLE = 2'h1;
  localparam CAL_MEAS = 2'h2;
  localparam CAL_DONE = 2'h3;
  reg [1:0] calState_r;
  reg [2:0] calIdx_r;
  reg [15:0] calCnt_r;
  reg [15:0] calStep_r;
  reg [15:0] calVolt_r;
  // Linear step is one eighth of the span from the minimum voltage to full scale
  wire [15:0] stepW = (16'hFFFF - uMin_r) >> 3;
  // Current is taken as linear in voltage, so the next point is predicted from
  // the last two and, from the second point on, a step that would cross the ceiling is never applied
  reg [15:0] calPrevI_r;
  wire [16:0] nextTwice = {currentMeas, 1'b0};
  wire [16:0] nextBound = {1'b0, iLim} + {1'b0, calPrevI_r};
  wire nextOver = (calIdx_r != 3'h0) && (nextTwice >= nextBound);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      calState_r <= CAL_IDLE;
      calIdx_r <= 3'h0;
      calCnt_r <= 16'h0000;
      calStep_r <= 16'h0000;
      calVolt_r <= 16'h0000;
      calPrevI_r <= 16'h0000;
      calBusy <= 1'b0;
      calValid_r <= 1'b0;
      calErr_r <= 1'b0;
      for (k = 0; k < `CAL_POINTS; k = k + 1) begin
        calV[k] <= 16'h0000;
        calI[k] <= 16'h0000;
        tmpV[k] <= 16'h0000;
        tmpI[k] <= 16'h0000;
      end
    end else begin
      case (calState_r)
        CAL_IDLE: begin
          if (calStartW) begin
            calBusy <= 1'b1;
            calErr_r <= 1'b0;
            calIdx_r <= 3'h0;
            calVolt_r <= uMin_r;
            calStep_r <= stepW;
            calCnt_r <= `CAL_SETTLE;
            calState_r <= CAL_SETTLE;
          end
        end
        CAL_SETTLE: begin
          if (calCnt_r == 16'h0000) begin
            calState_r <= CAL_MEAS;
          end else begin
            calCnt_r <= calCnt_r - 16'h0001;
          end
        end
        CAL_MEAS: begin
          tmpV[calIdx_r] <= calVolt_r; // [R10]
          tmpI[calIdx_r] <= currentMeas;
          if (calIdx_r == 3'h0 && currentMeas < `IMIN_LOAD) begin
            calErr_r <= 1'b1; // [R9]
            calBusy <= 1'b0;
            calState_r <= CAL_IDLE;
          end else if (currentMeas >= iLim || nextOver ||
                       calIdx_r == 3'h7) begin
            // Stop at the ceiling, before a step that would cross it, or at the end
            calState_r <= CAL_DONE; // [R8]
          end else begin
            calPrevI_r <= currentMeas;
            calIdx_r <= calIdx_r + 3'h1;
            calVolt_r <= calVolt_r + calStep_r;
            calCnt_r <= `CAL_SETTLE;
            calState_r <= CAL_SETTLE;
          end
        end
        CAL_DONE: begin
          // Commit only on success; pad unused points with the last voltage and an all-ones current
          for (k = 0; k < `CAL_POINTS; k = k + 1) begin
            calV[k] <= (k <= calIdx_r) ? tmpV[k] : tmpV[calIdx_r]; // [R10] [R20]
            calI[k] <= (k <= calIdx_r) ? tmpI[k] : 16'hFFFF;
          end
          calValid_r <= 1'b1;
          calBusy <= 1'b0;
          calState_r <= CAL_IDLE;
        end
        default: calState_r <= CAL_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Current to voltage lookup: first stored point at or above the set current
  reg [15:0] lutV;
  always @* begin
    lutV = calV[`CAL_POINTS-1];
    for (j = `CAL_POINTS - 1; j >= 0; j = j - 1) begin
      if (calI[j] >= iSet_r) begin
        lutV = calV[j];
      end
    end
  end

  // Voltage set point: direct write in voltage operation, recomputed in current
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vSet_r <= 16'h0000;
      prechargeVolt <= 16'h0000;
    end else begin
      if (wr && address == `REG_VSET && !effCur) begin
        vSet_r <= writedata[15:0];
      end else if (effCur && recompute_r) begin
        vSet_r <= (lutV < uMin_r) ? uMin_r : lutV; // [R3] [R4]
      end
      prechargeVolt <= calBusy ? calVolt_r : vSet_r;
    end
  end

  // Overcurrent flag, live in any driver mode; it stays set so software can
  // read why the output stopped, and a new event beats the clearing write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      overCur_r <= 1'b0;
    end else if (driverPresent && !calBusy && pulseOut && currentMeas > iMax_r) begin
      overCur_r <= 1'b1; // [R18]
    end else if (wr && address == `REG_CTRL && byteenable[0]) begin
      overCur_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Trigger qualification
  reg trigPrev_r;
  reg [15:0] burstLeft_r;
  wire rise = extTrigger & ~trigPrev_r;
  wire fall = ~extTrigger & trigPrev_r;
  wire isEdge = (trig_r == `TRIG_FALL) || (trig_r == `TRIG_RISE);
  wire edgeHit = (trig_r == `TRIG_RISE) ? rise : fall; // [R12]
  wire levelOk = (trig_r == `TRIG_HIGH) ? extTrigger : ~extTrigger; // [R14]
  wire internalMode = (trig_r == `TRIG_INT_A) || (trig_r == `TRIG_INT_B); // [R15]
  wire outOk = enable_r && !calBusy && !(overCur_r && driverPresent);
  reg [31:0] phase_r;
  wire periodEnd = (phase_r + 32'h1 >= period_r);
  wire running = internalMode ? 1'b1 : isEdge ? (burstLeft_r != 16'h0000) : levelOk;

  // Period counter and pulse output
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev_r <= 1'b0;
      burstLeft_r <= 16'h0000;
      phase_r <= 32'h0;
      pulseOut <= 1'b0;
    end else begin
      trigPrev_r <= extTrigger;
      if (!outOk || !running) begin
        phase_r <= 32'h0;
        pulseOut <= 1'b0;
        if (isEdge && edgeHit && outOk && burstLeft_r == 16'h0000) begin
          burstLeft_r <= shots_r; // [R13]
        end else if (!outOk) begin
          burstLeft_r <= 16'h0000;
        end
      end else begin
        // Further edges are ignored until the burst finishes
        phase_r <= periodEnd ? 32'h0 : phase_r + 32'h1; // [R17]
        // Output follows the current phase, so each pulse is full width unless outOk or the level condition drops first
        pulseOut <= (phase_r < width_r); // [R11]
        if (isEdge && periodEnd) begin
          burstLeft_r <= burstLeft_r - 16'h0001; // [R13]
        end
      end
    end
  end

  // ==========================================================================
  // Read mux
  wire [7:0] laserStatusWord = {modeRej_r, outOk, driverPresent, overCur_r & driverPresent,
                                calErr_r, calBusy, calValid_r, effCur};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0;
      response <= 2'h0;
    end else if (rd || wr) begin
      response <= 2'h0;
      readdata <= 32'h0;
      if (address == `REG_CTRL) begin
        readdata <= {30'h0, curMode_r, enable_r};
      end else if (address == `REG_WIDTH) begin
        readdata <= width_r;
      end else if (address == `REG_PERIOD) begin
        readdata <= period_r;
      end else if (address == `REG_TRIG) begin
        readdata <= {29'h0, trig_r};
      end else if (address == `REG_SHOTS) begin
        readdata <= {16'h0, shots_r};
      end else if (address == `REG_VSET) begin
        readdata <= {16'h0, vSet_r};
      end else if (address == `REG_ISET) begin
        readdata <= {16'h0, iSet_r};
      end else if (address == `REG_IMAX) begin
        readdata <= {16'h0, iMax_r};
      end else if (address == `REG_UMIN) begin
        readdata <= {16'h0, uMin_r};
      end else if (address == `REG_STATUS) begin
        readdata <= {24'h0, laserStatusWord};
      end else if (address == `REG_IMEAS) begin
        readdata <= {16'h0, currentMeas};
      end else begin
        response <= 2'h2; // Unmapped: slave error, reads zero
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/diode_driver_model.sv ----
// Behavioural laser driver: current follows precharge voltage linearly
`timescale 1ns/1ps
`default_nettype none
module diode_driver_model (
  // Bench control
  input wire logic attached,
  // From the pulse generator
  input wire logic [15:0] prechargeVolt,
  // To the pulse generator
  output logic driverPresent,
  output logic [15:0] currentMeas
);
  // ==========================================================
  // Presence and measurement
  // Fixed diode: a swapped part would need a new calibration run
  assign driverPresent = attached;
  assign currentMeas = attached ? (prechargeVolt >> 4) : 16'h0000;
endmodule
`default_nettype wire

// ---- tb/pulse_gen_monitor.sv ----
// Checker of bus handshake, pulse spacing, calibration length and voltage hold
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // Outputs
  input wire logic pulseOut,
  input wire logic [15:0] prechargeVolt,
  input wire logic calBusy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Helper logic
  logic [15:0] calCnt_r;
  wire req = read | write;
  wire ack = req & ~waitrequest;
  // Counts cycles of one calibration run, cleared when idle
  always @(posedge clk or posedge rst) begin
    if (rst) calCnt_r <= 16'h0000;
    else calCnt_r <= calBusy ? calCnt_r + 16'h0001 : 16'h0000;
  end
  // ==========================================================
  // Properties
  property p_first; req && !$past(req) |-> waitrequest; endproperty
  a_first: assert property (p_first) else $error("no wait in first cycle");
  property p_second; req && waitrequest |=> !waitrequest; endproperty
  a_second: assert property (p_second) else $error("no answer in second cycle");
  property p_idle; !req |-> !waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait without request");
  property p_unmapped; ack && address > 8'h28 |=> response == 2'h2; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  property p_mapped; ack && address <= 8'h28 && address[1:0] == 2'h0 |=> response == 2'h0;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access flagged");
  property p_gap; $fell(pulseOut) |-> !pulseOut [*4]; endproperty
  a_gap: assert property (p_gap) else $error("pulses too close");
  property p_cal_len; $fell(calBusy) |-> calCnt_r >= 16'h0100; endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration too short");
  property p_volt_hold;
    !calBusy && !$past(calBusy) && !$past(calBusy, 2) && !$past(write) && !$past(write, 2)
      && !$past(write, 3) |-> $stable(prechargeVolt);
  endproperty
  a_volt_hold: assert property (p_volt_hold) else $error("voltage moved unasked");
endmodule
bind triggered_pulse_generator pulse_gen_monitor u_mon (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .waitrequest(waitrequest),
  .response(response), .pulseOut(pulseOut), .prechargeVolt(prechargeVolt), .calBusy(calBusy));
`default_nettype wire

// ---- tb/triggered_pulse_generator_tb_top.sv ----
// Self-checking bench of the triggered pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "pulse_gen_defs.vh"
module triggered_pulse_generator_tb_top;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, extTrigger = 1'b0, attached = 1'b1;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h00000000, q;
  logic [3:0] byteenable = 4'hF;
  logic [15:0] v1, mx;
  wire [31:0] readdata;
  wire [1:0] response;
  wire [15:0] currentMeas, prechargeVolt;
  wire waitrequest, driverPresent, pulseOut, calBusy;
  int fails = 0, tests_run = 0, hc, rc;
  // ==========================================================
  // Clock, design and far side
  always #12.5 clk = ~clk;
  triggered_pulse_generator u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .driverPresent(driverPresent),
    .extTrigger(extTrigger), .currentMeas(currentMeas), .pulseOut(pulseOut),
    .prechargeVolt(prechargeVolt), .calBusy(calBusy));
  diode_driver_model u_drv (.attached(attached), .prechargeVolt(prechargeVolt),
    .driverPresent(driverPresent), .currentMeas(currentMeas));
  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge; a stuck
  // slave is left to the watchdog
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task st(input int b, input logic v);
    bus(1'b0, `REG_STATUS, 32'h0);
    check(32'(q[b]), 32'(v));
  endtask
  // Counts high cycles and rising edges of the pulse output
  task pulses(input int n);
    logic p;
    repeat (n) begin
      p = pulseOut;
      @(negedge clk);
      hc += 32'(pulseOut === 1'b1);
      rc += 32'(pulseOut === 1'b1 && p === 1'b0);
    end
  endtask
  task setTrig(input logic v);
    @(posedge clk) extTrigger <= v;
  endtask
  task calRun;
    int n;
    n = 0;
    mx = 16'h0000;
    bus(1'b1, `REG_CTRL, 32'h4);
    while ((calBusy !== 1'b0 || n < 4) && n < 5000) begin
      @(negedge clk) n++;
      if (calBusy === 1'b1 && currentMeas > mx) mx = currentMeas;
    end
    if (n >= 5000) fails++;
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    st(`ST_CURMODE, 1'b0);
    st(`ST_DRIVER, 1'b1);
    bus(1'b0, `REG_TRIG, 32'h0);
    check(32'(q[2:0]), 32'(`TRIG_RST));
    bus(1'b0, 8'h40, 32'h0);
    check(32'(response), 32'h2);
    bus(1'b1, `REG_CTRL, 32'h2);
    st(`ST_CURMODE, 1'b0);
    bus(1'b1, `REG_TRIG, 32'h6);
    bus(1'b0, `REG_TRIG, 32'h0);
    check(32'(q[2:0]), 32'(`TRIG_RST));
    st(`ST_MODEREJ, 1'b1);
  endtask
  task t_internal;
    bus(1'b1, `REG_CTRL, 32'h1);
    for (int c = 2; c <= 3; c++) begin
      bus(1'b1, `REG_TRIG, 32'(c));
      setTrig(c == 3);
      hc = 0;
      pulses(400);
      check(hc, 40);
    end
    bus(1'b1, `REG_CTRL, 32'h0);
    pulses(40);
    hc = 0;
    pulses(400);
    check(hc, 0);
    bus(1'b1, `REG_CTRL, 32'h1);
  endtask
  task t_level;
    for (int c = 4; c <= 5; c++) begin
      setTrig(c == 5);
      bus(1'b1, `REG_TRIG, 32'(c));
      pulses(40);
      hc = 0;
      pulses(400);
      check(hc, 40);
      setTrig(c != 5);
      pulses(40);
      hc = 0;
      pulses(400);
      check(hc, 0);
    end
  endtask
  // Second qualifying edge lands mid-burst and must not add pulses
  task t_edge;
    bus(1'b1, `REG_SHOTS, 32'h3);
    for (int c = 0; c <= 1; c++) begin
      bus(1'b1, `REG_TRIG, 32'(c));
      setTrig(c == 0);
      hc = 0;
      rc = 0;
      pulses(80);
      check(hc, 0);
      setTrig(c != 0);
      pulses(10);
      check(rc, 1);
      setTrig(c == 0);
      pulses(20);
      setTrig(c != 0);
      pulses(270);
      check(rc, 3);
      check(hc, 12);
    end
  endtask
  task t_alone;
    @(posedge clk) attached <= 1'b0;
    bus(1'b1, `REG_TRIG, 32'h2);
    st(`ST_DRIVER, 1'b0);
    pulses(40);
    hc = 0;
    pulses(400);
    check(hc, 40);
    @(posedge clk) attached <= 1'b1;
  endtask
  task t_cal;
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_UMIN, 32'h0080);
    calRun;
    st(`ST_CALERR, 1'b1);
    st(`ST_CALVALID, 1'b0);
    bus(1'b1, `REG_CTRL, 32'h2);
    st(`ST_CURMODE, 1'b0);
    bus(1'b1, `REG_IMAX, 32'h0900);
    bus(1'b1, `REG_UMIN, 32'h1000);
    calRun;
    check(32'(mx <= 16'(32'h900 * 99 / 100)), 32'h1);
    st(`ST_CALVALID, 1'b1);
    bus(1'b1, `REG_CTRL, 32'h2);
    st(`ST_CURMODE, 1'b1);
    bus(1'b1, `REG_ISET, 32'h0400);
    pulses(4);
    v1 = prechargeVolt;
    check(32'(v1 >= 16'h1000), 32'h1);
    bus(1'b1, `REG_ISET, 32'h0600);
    pulses(4);
    check(32'(prechargeVolt > v1), 32'h1);
    bus(1'b1, `REG_ISET, 32'hFFFF);
    bus(1'b0, `REG_ISET, 32'h0);
    check(32'(q[15:0]), 32'h0900);
  endtask
  task t_over;
    bus(1'b1, `REG_CTRL, 32'h0);
    bus(1'b1, `REG_IMAX, 32'h0100);
    bus(1'b1, `REG_VSET, 32'h4000);
    bus(1'b1, `REG_CTRL, 32'h1);
    pulses(100);
    st(`ST_OVERCUR, 1'b1);
    st(`ST_OUTEN, 1'b0);
    hc = 0;
    pulses(200);
    check(hc, 0);
  endtask
  // ==========================================================
  // Verdict, main sequence and watchdog
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_internal;
    t_level;
    t_edge;
    t_alone;
    t_cal;
    t_over;
    stop_test;
  end
  // Whole run needs about 6000 cycles; this allows ten times that
  initial begin
    #(25 * 60000);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
